// File: hdl/flash_writer_pkg.sv
// Constants for the writer-mode command port of the on-chip flash.
// Assumes one 250 MHz system clock; the port and the programmer model depend on nothing but this package.
package flash_writer_pkg;
	// ==========================================================================
	// Geometry
	localparam int ADDR_W     = 18;
	localparam int DATA_W     = 8;
	localparam int MEM_DEPTH  = 65536;
	localparam int MEM_AW     = 16;
	localparam int BLOCK_LEN  = 128;
	localparam int CNT_W      = 8;
	// ==========================================================================
	// Command codes, erased byte and block address low bytes
	localparam logic [7:0] CMD_READ    = 8'h00;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ERASE   = 8'h20;
	localparam logic [7:0] CMD_STATUS  = 8'h71;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] BLOCK_LOW_A = 8'h00;
	localparam logic [7:0] BLOCK_LOW_B = 8'h80;
	// ==========================================================================
	// Status byte fields
	localparam int END_BIT        = 7;
	localparam int PASS_BIT       = 6;
	localparam int CMD_ERR_BIT    = 6;
	localparam int PROG_ERR_BIT   = 5;
	localparam int ERASE_ERR_BIT  = 4;
	localparam int COUNT_EXC_BIT  = 1;
	localparam int BAD_ADDR_BIT   = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// ==========================================================================
	// Timing
	localparam int CLK_MHZ       = 250;
	localparam int SETTLE_MS     = 10;
	localparam int SETUP_MS      = 10;
	localparam int SETTLE_CYCLES = (SETTLE_MS + SETUP_MS) * CLK_MHZ * 1000;
	localparam int WRITE_MS      = 1;
	localparam int WRITE_CYCLES  = WRITE_MS * CLK_MHZ * 1000;
	localparam int ERASE_MS      = 100;
	localparam int ERASE_CYCLES  = ERASE_MS * CLK_MHZ * 1000;
	localparam int TIMER_W       = 32;
	// ==========================================================================
	// Sequencer states and output source select
	typedef enum logic [2:0] {
		ST_SETTLE, ST_WAIT, ST_READ, ST_PROG_LOAD, ST_PROG_RUN,
		ST_ERASE_ARM, ST_ERASE_RUN, ST_STATUS_ARM
	} state_t;
	typedef enum logic [1:0] {OUT_POLL, OUT_ARRAY, OUT_STATUS} outsel_t;
endpackage

// File: hdl/flash_writer_port.sv
// Writer-mode command port: decodes the programmer's strobes and runs the flash sequences.
// Assumes the strobes and buses come straight from socket pins, asynchronous to CLK_SYS.
//
// Overview of operation
// R1 - In read mode each read returns the array byte at the presented address.
// R2 - Program writes one 128-byte block; completion shows through status polling.
// R3 - Erase clears the whole array; completion by polling; no partial erase.
// R4 - Select, gate and strobe decode into read, output disable, command write, chip disable.
// R5 - Deselect only floats the data pins; internal logic keeps running.
// R6 - Read command is one write of 00 then any number of reads.
// R7 - Program command is 40 then 128 address and data writes, 129 in all.
// R8 - Erase is 20 written twice; status read is 71 written twice; the port takes any byte as the second status write.
// R9 - After program, erase or status read the device waits for a command.
// R10 - Read mode decodes command writes exactly like the command wait state.
// R11 - Read mode serves any number of reads without another command.
// R12 - After power-up the device sits in read mode.
// R13 - Programmer pads short blocks with FF bytes.
// R14 - Programmer gives block addresses with low byte 00 or 80.
// R15 - A misaligned block address still programs but flags a write error.
// R16 - Block address is captured from the second sequence cycle only.
// R17 - Programmer issues no command while programming runs.
// R18 - Programmer programs each block only once.
// R19 - Pass pin judges success; end pin marks completion; status read also checks.
// R20 - Polling pins hold until the next command write, readable when selected.
// R21 - Status read mode drives error details of the last program or erase.
// R22 - Polling: both 0 busy, end only abnormal, both 1 normal; others 0.
// R23 - Status byte: end, command, program, erase, count and address error bits.
// R24 - Status return code holds until a command for another mode.
// R25 - Commands are ignored during 20 ms settling and setup, then read mode.
// R26 - Internal block write starts only after the 128th data byte is latched.
`timescale 1ns/1ps
`default_nettype none
module flash_writer_port
	import flash_writer_pkg::*;
#(
	parameter int SETTLE_CNT = SETTLE_CYCLES,
	parameter int WRITE_CNT  = WRITE_CYCLES,
	parameter int ERASE_CNT  = ERASE_CYCLES
)
(
	input  wire logic                                 CLK_SYS,
	input  wire logic                                 RESET_N,
	input  wire logic                                 CHIP_SEL_N,
	input  wire logic                                 OUT_GATE_N,
	input  wire logic                                 WRITE_STROBE_N,
	input  wire logic [flash_writer_pkg::ADDR_W-1:0]  FLASH_ADDR_PINS,
	input  wire logic [flash_writer_pkg::DATA_W-1:0]  FLASH_DATA_PINS_IN,
	output logic      [flash_writer_pkg::DATA_W-1:0]  FLASH_DATA_PINS_OUT,
	output logic                                      FLASH_DATA_PINS_OE_N,
	output logic                                      BUSY
);
	import flash_writer_pkg::*;

	// ==========================================================================
	// Pin synchronisers
	// Two flops on every pin; the first stage is read by nothing but the second.
	logic [2:0]        ctl_meta_ff, ctl_ff, ctl_prev_ff;
	logic [ADDR_W-1:0] addr_meta_ff, addr_ff;
	logic [DATA_W-1:0] din_meta_ff, din_ff;
	always_ff @(posedge CLK_SYS)
	begin
		ctl_meta_ff  <= {CHIP_SEL_N, OUT_GATE_N, WRITE_STROBE_N};
		ctl_ff       <= ctl_meta_ff;
		addr_meta_ff <= FLASH_ADDR_PINS;
		addr_ff      <= addr_meta_ff;
		din_meta_ff  <= FLASH_DATA_PINS_IN;
		din_ff       <= din_meta_ff;
	end

	// Previous strobe levels; reset to idle so no false edge after reset.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			ctl_prev_ff <= 3'b111;
		else
			ctl_prev_ff <= ctl_ff;
	end

	// ==========================================================================
	// Bus mode decode
	logic sel, gate, strobe, strobe_prev, cmd_write, read_en;
	assign sel         = !ctl_ff[2];
	assign gate        = !ctl_ff[1];
	assign strobe      = !ctl_ff[0];
	assign strobe_prev = !ctl_prev_ff[0] && !ctl_prev_ff[2] && ctl_prev_ff[1];
	// A write is taken at the rising edge of the strobe, when data is settled.
	assign cmd_write   = strobe_prev && !(sel && !gate && strobe); // R4
	assign read_en     = sel && gate && !strobe; // R4

	// ==========================================================================
	// Sequencer state, timer and block counter
	state_t             state_ff;
	logic [TIMER_W-1:0] timer_ff;
	logic [CNT_W-1:0]   count_ff;
	logic [ADDR_W-1:0]  block_addr_ff;
	logic               op_done;
	assign op_done = (timer_ff == '0);

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			state_ff <= ST_SETTLE;
		else
		begin
			unique case (state_ff)
				ST_SETTLE:
					if (op_done)
						state_ff <= ST_READ; // R12 R25
				ST_WAIT, ST_READ: // R10
					if (cmd_write)
					begin
						if (din_ff == CMD_READ)
							state_ff <= ST_READ; // R6 R11
						else if (din_ff == CMD_PROGRAM)
							state_ff <= ST_PROG_LOAD; // R7
						else if (din_ff == CMD_ERASE)
							state_ff <= ST_ERASE_ARM; // R8
						else if (din_ff == CMD_STATUS)
							state_ff <= ST_STATUS_ARM; // R8
						else
							state_ff <= ST_WAIT;
					end
				ST_PROG_LOAD:
					if (cmd_write && count_ff == CNT_W'(BLOCK_LEN - 1))
						state_ff <= ST_PROG_RUN; // R26
				ST_PROG_RUN, ST_ERASE_RUN:
					if (op_done)
						state_ff <= ST_WAIT; // R9
				ST_ERASE_ARM:
					if (cmd_write)
						state_ff <= (din_ff == CMD_ERASE) ? ST_ERASE_RUN : ST_WAIT; // R8
				ST_STATUS_ARM:
					if (cmd_write)
						state_ff <= ST_WAIT; // R9
			endcase
		end
	end

	// Countdown timer for settling, block write and erase; commands during
	// a running operation are simply not decoded.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			timer_ff <= TIMER_W'(SETTLE_CNT); // R25
		else if (state_ff == ST_PROG_LOAD && cmd_write && count_ff == CNT_W'(BLOCK_LEN - 1))
			timer_ff <= TIMER_W'(WRITE_CNT);
		else if (state_ff == ST_ERASE_ARM && cmd_write && din_ff == CMD_ERASE)
			timer_ff <= TIMER_W'(ERASE_CNT);
		else if (!op_done)
			timer_ff <= timer_ff - 1'b1;
	end

	// Byte counter and block address; the address is taken from the first data write only.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			count_ff      <= '0;
			block_addr_ff <= '0;
		end
		else if (state_ff != ST_PROG_LOAD)
			count_ff <= '0;
		else if (cmd_write)
		begin
			count_ff <= count_ff + 1'b1; // R26
			if (count_ff == '0)
				block_addr_ff <= addr_ff; // R16
		end
	end

	// ==========================================================================
	// Array and page buffer
	// The page buffer holds the 128 bytes until the whole block is in.
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic [DATA_W-1:0] page [BLOCK_LEN];
	logic [CNT_W-1:0]  wcount_ff;
	logic [DATA_W-1:0] rd_data_ff;
	logic [MEM_AW-1:0] wbase;
	assign wbase = {block_addr_ff[MEM_AW-1:7], 7'h00};

	always_ff @(posedge CLK_SYS)
	begin
		if (state_ff == ST_PROG_LOAD && cmd_write)
			page[count_ff[6:0]] <= din_ff; // R2
	end

	// Erase and program walk the array one byte a cycle while the timer runs.
	// Programming can only clear bits, which models the once-per-block limit.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			wcount_ff <= '0;
		else if (state_ff == ST_PROG_RUN && !wcount_ff[7])
		begin
			mem[wbase | MEM_AW'(wcount_ff[6:0])] <=
				mem[wbase | MEM_AW'(wcount_ff[6:0])] & page[wcount_ff[6:0]]; // R2 R15
			wcount_ff <= wcount_ff + 1'b1;
		end
		else if (state_ff == ST_ERASE_RUN)
			mem[MEM_AW'(timer_ff)] <= ERASED_BYTE; // R3
		else if (state_ff != ST_PROG_RUN)
			wcount_ff <= '0;
	end

	// Registered array read at the presented address.
	always_ff @(posedge CLK_SYS)
	begin
		rd_data_ff <= mem[addr_ff[MEM_AW-1:0]]; // R1
	end

	// ==========================================================================
	// Polling and status flags
	logic       end_flag_ff, pass_flag_ff;
	logic [7:0] status_ff;
	outsel_t    outsel_ff;
	logic       bad_addr;
	assign bad_addr = block_addr_ff[7:0] != BLOCK_LOW_A && block_addr_ff[7:0] != BLOCK_LOW_B;

	// Polling pins clear on any command write; at an operation end the end pin sets and the pass pin sets unless the block is misaligned.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			end_flag_ff  <= 1'b0;
			pass_flag_ff <= 1'b0;
		end
		else if ((state_ff == ST_PROG_RUN || state_ff == ST_ERASE_RUN) && op_done)
		begin
			end_flag_ff  <= 1'b1; // R22
			pass_flag_ff <= !(state_ff == ST_PROG_RUN && bad_addr); // R19 R22
		end
		else if (cmd_write)
		begin
			end_flag_ff  <= 1'b0; // R20
			pass_flag_ff <= 1'b0;
		end
	end

	// Return code: rebuilt at each operation end, cleared by a command for another mode.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			status_ff <= STATUS_RESET;
		else if (state_ff == ST_PROG_RUN && op_done && bad_addr)
		begin
			status_ff                <= STATUS_RESET;
			status_ff[END_BIT]       <= 1'b1; // R15 R23
			status_ff[PROG_ERR_BIT]  <= 1'b1;
			status_ff[BAD_ADDR_BIT]  <= 1'b1;
		end
		else if ((state_ff == ST_PROG_RUN || state_ff == ST_ERASE_RUN) && op_done)
			status_ff <= STATUS_RESET;
		else if (state_ff == ST_ERASE_ARM && cmd_write && din_ff != CMD_ERASE)
		begin
			status_ff[END_BIT]     <= 1'b1; // R23
			status_ff[CMD_ERR_BIT] <= 1'b1;
		end
		else if ((state_ff == ST_WAIT || state_ff == ST_READ) && cmd_write
				&& din_ff != CMD_STATUS)
			status_ff <= STATUS_RESET; // R24
	end

	// Output source selection follows the last decoded command.
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
			outsel_ff <= OUT_ARRAY; // R12
		else if (state_ff == ST_STATUS_ARM && cmd_write)
			outsel_ff <= OUT_STATUS; // R21
		else if ((state_ff == ST_WAIT || state_ff == ST_READ) && cmd_write)
			outsel_ff <= (din_ff == CMD_READ) ? OUT_ARRAY : OUT_POLL;
	end

	// ==========================================================================
	// Data pins
	// Drivers float whenever not selected for read; logic carries on (R5).
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESET_N)
		begin
			FLASH_DATA_PINS_OUT  <= '0;
			FLASH_DATA_PINS_OE_N <= 1'b1;
		end
		else
		begin
			FLASH_DATA_PINS_OE_N <= !read_en; // R4 R5
			if (state_ff == ST_READ && outsel_ff == OUT_ARRAY)
				FLASH_DATA_PINS_OUT <= rd_data_ff; // R1 R11
			else if (outsel_ff == OUT_STATUS)
				FLASH_DATA_PINS_OUT <= status_ff; // R21 R24
			else
				FLASH_DATA_PINS_OUT <= {end_flag_ff, pass_flag_ff, 6'h00}; // R20 R22
		end
	end

	assign BUSY = state_ff == ST_SETTLE || state_ff == ST_PROG_RUN || state_ff == ST_ERASE_RUN;

	// ==========================================================================
	// Checks
	// Pin drive follows the read select one cycle later; a read held through reset is excused.
	a_float_unselected: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R4
		!$past(read_en) |-> FLASH_DATA_PINS_OE_N)
		else $error("Data pins driven while not read-selected.");
	a_drive_selected: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R5
		$past(read_en) && $past(RESET_N) |-> !FLASH_DATA_PINS_OE_N)
		else $error("Data pins not driven during read.");
	// Sequencer steps against the command sequences.
	a_prog_after_block: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R26
		state_ff == ST_PROG_LOAD && !(cmd_write && count_ff == 8'd127)
		|=> state_ff == ST_PROG_LOAD)
		else $error("Program started before 128 bytes.");
	a_block_addr_once: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R16
		state_ff == ST_PROG_LOAD && cmd_write && count_ff != '0 |=> $stable(block_addr_ff))
		else $error("Block address taken after the first data write.");
	a_erase_twice: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R8
		$rose(state_ff == ST_ERASE_RUN) |-> $past(state_ff == ST_ERASE_ARM))
		else $error("Erase without second command byte.");
	a_settle_ignore: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R25
		state_ff == ST_SETTLE && !op_done |=> state_ff == ST_SETTLE)
		else $error("Settling period cut short.");
	a_back_to_wait: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R9
		state_ff == ST_ERASE_RUN && op_done |=> state_ff == ST_WAIT)
		else $error("No return to command wait.");
	a_read_cmd: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R6
		state_ff == ST_WAIT && cmd_write && din_ff == CMD_READ |=> state_ff == ST_READ)
		else $error("Read command not taken.");
	// Polling pins and return code change only at operation ends and command writes.
	a_poll_busy_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R22
		$past(state_ff == ST_PROG_RUN && !op_done) |-> !end_flag_ff)
		else $error("End flag set while busy.");
	a_poll_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R20
		state_ff == ST_WAIT && !cmd_write |=> $stable(end_flag_ff))
		else $error("Polling flag changed without command.");
	a_poll_low_bits: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R22
		outsel_ff == OUT_POLL |=> FLASH_DATA_PINS_OUT[5:0] == 6'h00)
		else $error("Polling byte carries stray low bits.");
	a_status_hold: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R24
		!cmd_write && !((state_ff == ST_PROG_RUN || state_ff == ST_ERASE_RUN) && op_done)
		|=> $stable(status_ff))
		else $error("Return code changed without a command.");
	a_misaligned_flag: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // R15
		state_ff == ST_PROG_RUN && op_done && bad_addr |=> status_ff[BAD_ADDR_BIT]
		&& !pass_flag_ff && end_flag_ff)
		else $error("Misaligned block not flagged.");
	c_program: cover property (@(posedge CLK_SYS) state_ff == ST_PROG_RUN ##1 state_ff == ST_WAIT);
	c_erase: cover property (@(posedge CLK_SYS) state_ff == ST_ERASE_RUN ##1 state_ff == ST_WAIT);
	c_status: cover property (@(posedge CLK_SYS) outsel_ff == OUT_STATUS && read_en);
	c_misaligned: cover property (@(posedge CLK_SYS) state_ff == ST_PROG_RUN && op_done && bad_addr);
endmodule
`default_nettype wire

// File: dv/flash_programmer_model.sv
// Programmer model: drives select, gate, strobe, address and data like a PROM programmer.
// Assumes the bench resolves the shared data wire and calls these tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module flash_programmer_model
	import flash_writer_pkg::*;
(
	input  wire logic                                CLK_SYS,
	input  wire logic [flash_writer_pkg::DATA_W-1:0] DATA_WIRE,
	output logic                                     CHIP_SEL_N,
	output logic                                     OUT_GATE_N,
	output logic                                     WRITE_STROBE_N,
	output logic      [flash_writer_pkg::ADDR_W-1:0] ADDR,
	output logic      [flash_writer_pkg::DATA_W-1:0] DATA_DRV
);
	import flash_writer_pkg::*;

	// ==========================================================================
	// Idle pins
	// The bus starts deselected; the released data lines never repeat a real value.
	initial
	begin
		CHIP_SEL_N = 1'b1;
		OUT_GATE_N = 1'b1;
		WRITE_STROBE_N = 1'b1;
		ADDR = '0;
		DATA_DRV = 8'ha5;
	end
	// ==========================================================================
	// Bus cycles
	// Every pin change lands just after a rising edge, so the sync flops never race it.
	task automatic step(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	// Select and gate are held for eight cycles, twice the answer latency.
	task automatic hold(input logic sel_n, input logic gate_n, input logic [ADDR_W-1:0] a);
		step(1);
		CHIP_SEL_N = sel_n;
		OUT_GATE_N = gate_n;
		ADDR = a;
		step(8);
	endtask
	// Command write: select low, gate high, strobe pulsed low; data kept well past the rise.
	task automatic write_cycle(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		step(1);
		CHIP_SEL_N = 1'b0;
		OUT_GATE_N = 1'b1;
		ADDR = a;
		DATA_DRV = d;
		step(1);
		WRITE_STROBE_N = 1'b0;
		step(4);
		WRITE_STROBE_N = 1'b1;
		step(4);
		CHIP_SEL_N = 1'b1;
		DATA_DRV = ~d; // Released lines show the inverse, never a stale match.
		ADDR = ~a;
		step(4);
	endtask
	// Read: select and gate low, sample the wire, then deselect.
	task automatic read_cycle(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		hold(1'b0, 1'b0, a);
		d = DATA_WIRE;
		hold(1'b1, 1'b1, ~a);
	endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// Bench for the writer-mode command port: sequences of programmer bus cycles with expectations.
// Assumes the programmer model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import flash_writer_pkg::*;
	localparam int LIMIT = 95000;
	logic              clk_sys = 1'b0;
	logic              reset_n = 1'b0;
	logic              sel_n;
	logic              gate_n;
	logic              strobe_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] drv;
	logic [DATA_W-1:0] dout;
	logic              oe_n;
	logic              busy;
	wire  [DATA_W-1:0] data_wire;
	int                fail_count = 0;
	int                compares = 0;
	int                cycles = 0;
	logic [DATA_W-1:0] d;
	// ==========================================================================
	// Clock, wire and instances
	always #2 clk_sys = ~clk_sys;
	// The data wire carries the device's value only while its enable is low.
	assign data_wire = (oe_n === 1'b0) ? dout : drv;
	flash_writer_port #(.SETTLE_CNT(300), .WRITE_CNT(300), .ERASE_CNT(65536)) dut (
		.CLK_SYS(clk_sys), .RESET_N(reset_n), .CHIP_SEL_N(sel_n), .OUT_GATE_N(gate_n),
		.WRITE_STROBE_N(strobe_n), .FLASH_ADDR_PINS(addr), .FLASH_DATA_PINS_IN(data_wire),
		.FLASH_DATA_PINS_OUT(dout), .FLASH_DATA_PINS_OE_N(oe_n), .BUSY(busy));
	flash_programmer_model prog (
		.CLK_SYS(clk_sys), .DATA_WIRE(data_wire), .CHIP_SEL_N(sel_n), .OUT_GATE_N(gate_n),
		.WRITE_STROBE_N(strobe_n), .ADDR(addr), .DATA_DRV(drv));
	// ==========================================================================
	// Checking and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// A hung handshake must still reach the verdict.
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			fail_count++;
			end_of_test();
		end
	end
	// ==========================================================================
	// Access helpers
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] mask, input logic [7:0] exp);
		logic [7:0] v;
		prog.read_cycle(a, v);
		check(v & mask, exp);
	endtask
	task automatic wr2(input logic [7:0] c);
		prog.write_cycle(18'h00000, c);
		prog.write_cycle(18'h3ffff, c);
	endtask
	// Bounded wait for the busy level; a miss shows up as one mismatch.
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 70000)
		begin
			prog.step(1);
			n++;
		end
		check({7'h0, busy}, {7'h0, lvl});
	endtask
	// Only the first data write carries the block address; later ones carry junk.
	task automatic prog_block(input logic [ADDR_W-1:0] blk);
		prog.write_cycle(18'h00000, CMD_PROGRAM);
		for (int i = 0; i < BLOCK_LEN; i++)
		begin
			prog.write_cycle((i == 0) ? blk : 18'h3ff7f, (i < 120) ? (8'(i) ^ 8'h5a) : 8'hff);
			if (i < BLOCK_LEN - 1)
				check({7'h0, busy}, 8'h00);
		end
		wait_busy(1'b1);
		wait_busy(1'b0);
	endtask
	// ==========================================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		check({7'h0, busy}, 8'h01);
		wr2(CMD_ERASE);
		wait_busy(1'b0);
		prog.step(20);
		check({7'h0, busy}, 8'h00);
		// Read mode straight after settling, then output-disable and deselect.
		prog.hold(1'b0, 1'b0, 18'h00010);
		check({7'h0, oe_n}, 8'h00);
		prog.hold(1'b0, 1'b1, 18'h00010);
		check({7'h0, oe_n}, 8'h01);
		prog.hold(1'b1, 1'b0, 18'h00010);
		check({7'h0, oe_n}, 8'h01);
		// Whole-array erase with polling during and after.
		wr2(CMD_ERASE);
		wait_busy(1'b1);
		rd(18'h00000, 8'hff, 8'h00);
		wait_busy(1'b0);
		rd(18'h00000, 8'hff, 8'hc0);
		rd(18'h12345, 8'hff, 8'hc0);
		prog.write_cycle(18'h2aaaa, CMD_READ);
		rd(18'h00000, 8'hff, 8'hff);
		rd(18'h0ffff, 8'hff, 8'hff);
		// Aligned block: poll first, then the read command before reading back.
		prog_block(18'h00180);
		rd(18'h00000, 8'hff, 8'hc0);
		prog.write_cycle(18'h00000, CMD_READ);
		for (int i = 0; i < BLOCK_LEN; i += 9)
			rd(18'h00180 + 18'(i), 8'hff, (i < 120) ? (8'(i) ^ 8'h5a) : 8'hff);
		// Misaligned block still writes but flags the error.
		prog_block(18'h00205);
		rd(18'h00000, 8'hff, 8'h80);
		wr2(CMD_STATUS);
		rd(18'h00000, 8'hf3, 8'ha1);
		rd(18'h00077, 8'hf3, 8'ha1);
		prog.write_cycle(18'h00000, CMD_READ);
		rd(18'h00201, 8'hff, 8'h5b);
		wr2(CMD_STATUS);
		rd(18'h00000, 8'hf3, 8'h00);
		// Broken erase sequence gives a command error.
		prog.write_cycle(18'h00000, CMD_ERASE);
		prog.write_cycle(18'h00000, 8'h55);
		wr2(CMD_STATUS);
		rd(18'h00000, 8'hf3, 8'hc0);
		prog.write_cycle(18'h00000, CMD_READ);
		rd(18'h00201, 8'hff, 8'h5b);
		// An unknown code leaves read mode for the wait state with cleared polling pins.
		prog.write_cycle(18'h00000, 8'h55);
		rd(18'h00201, 8'hff, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
